// ### lnpc_regs.v
// Node identity, PHY register mailbox and cycle timer behind APB.
// Assumes PHY status, reply and cycle start inputs come from logic
// on pclk; only the external cycle tick is an asynchronous pin.
`timescale 1ns/1ps
`include "lnpc_defs.vh"

module lnpc_regs #(
    parameter ADDR_W = 8
) (
    input  wire              pclk,
    input  wire              presetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output wire              pready,
    output wire              pslverr,
    output wire [31:0]       prdata,
    input  wire              phy_bus_reset,
    input  wire              phy_node_strobe,
    input  wire [5:0]        phy_node_number,
    input  wire              phy_is_root,
    input  wire              phy_cable_power,
    input  wire              phy_reg_strobe,
    input  wire [3:0]        phy_reg_addr,
    input  wire [7:0]        phy_reg_data,
    output wire              phy_link_request,
    output wire [15:0]       node_id,
    input  wire              offset_tick,
    input  wire              external_tick_input,
    input  wire              rx_cycle_start,
    input  wire [31:0]       rx_cycle_time,
    output wire              tx_cycle_start,
    output wire [31:0]       tx_cycle_time
);

    // ====================================================
    // Serializer states
    localparam [1:0] ST_IDLE  = 2'b01;
    localparam [1:0] ST_SHIFT = 2'b10;

    // ====================================================
    // Storage
    reg        node_valid_flag_q;
    reg        root_q;
    reg        cable_power_ok_flag_q;
    reg [9:0]  bus_id_field_q;
    reg [5:0]  phys_node_field_q;
    reg        phy_read_complete_q;
    reg [3:0]  phy_rx_reg_addr_q;
    reg [7:0]  phy_rx_reg_value_q;
    reg        phy_read_request_q;
    reg        phy_write_request_q;
    reg [3:0]  phy_target_addr_q;
    reg [7:0]  phy_write_value_q;
    reg [6:0]  timer_seconds_field_q;
    reg [12:0] cycle_number_field_q;
    reg [11:0] subcycle_tick_field_q;
    reg        time_count_enable_q;
    reg        timing_master_enable_q;
    reg        external_rollover_select_q;
    reg [31:0] prdata_q;
    reg [1:0]  state_q;
    reg [16:0] shift_q;
    reg [4:0]  left_q;
    reg        lreq_q;
    reg        ext_s1_q;
    reg        ext_s2_q;
    reg        ext_s3_q;
    reg        ext_lvl_q;
    reg        cs_pulse_q;
    reg [31:0] cs_time_q;

    reg [6:0]  sec_d;
    reg [12:0] cyc_d;
    reg [11:0] ofs_d;
    reg [31:0] rd_mux;

    wire        setup_ph;
    wire        write_ph;
    wire        hit_node;
    wire        hit_phy;
    wire        hit_time;
    wire        hit_ctrl;
    wire        hit_any;
    wire        wr_node;
    wire        wr_phy;
    wire        wr_time;
    wire        wr_ctrl;
    wire        sw_rd_set;
    wire        sw_wr_set;
    wire        ext_rise;
    wire        count_tick;
    wire        ofs_last;
    wire        roll;
    wire [31:0] node_word;
    wire [31:0] phy_word;
    wire [31:0] time_word;
    wire [31:0] ctrl_word;

    // ====================================================
    // APB decode; zero wait state, so the answer is ready at access
    assign setup_ph = psel & ~penable;
    assign write_ph = psel & penable & pwrite;
    assign hit_node = (paddr == `LNPC_ADDR_NODE);
    assign hit_phy  = (paddr == `LNPC_ADDR_PHY);
    assign hit_time = (paddr == `LNPC_ADDR_TIME);
    assign hit_ctrl = (paddr == `LNPC_ADDR_CTRL);
    assign hit_any  = hit_node | hit_phy | hit_time | hit_ctrl;
    assign wr_node  = write_ph & hit_node;
    assign wr_phy   = write_ph & hit_phy;
    assign wr_time  = write_ph & hit_time;
    assign wr_ctrl  = write_ph & hit_ctrl;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~hit_any;
    assign prdata   = prdata_q;

    // Only a written one starts a request; zeros never abort one
    assign sw_rd_set = wr_phy & pwdata[`LNPC_RD_BIT];
    assign sw_wr_set = wr_phy & pwdata[`LNPC_WR_BIT];

    // ====================================================
    // Read words; reserved bits stay zero
    assign node_word = {node_valid_flag_q,
                        root_q,
                        2'b00,
                        cable_power_ok_flag_q,
                        11'h000,
                        bus_id_field_q,
                        phys_node_field_q};
    assign phy_word  = {phy_read_complete_q,
                        3'h0,
                        phy_rx_reg_addr_q,
                        phy_rx_reg_value_q,
                        phy_read_request_q,
                        phy_write_request_q,
                        2'b00,
                        phy_target_addr_q,
                        phy_write_value_q};
    assign time_word = {timer_seconds_field_q,
                        cycle_number_field_q,
                        subcycle_tick_field_q};
    assign ctrl_word = {29'h00000000,
                        external_rollover_select_q,
                        timing_master_enable_q,
                        time_count_enable_q};

    assign node_id = {bus_id_field_q, phys_node_field_q};

    // Read multiplexer; unmapped reads return zero
    always @* begin
        rd_mux = 32'h00000000;
        if (hit_node) begin
            rd_mux = node_word;
        end else if (hit_phy) begin
            rd_mux = phy_word;
        end else if (hit_time) begin
            rd_mux = time_word;
        end else if (hit_ctrl) begin
            rd_mux = ctrl_word;
        end
    end

    // Read data is captured in setup so it comes from a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (setup_ph & ~pwrite) begin
            prdata_q <= rd_mux;
        end
    end

    // ====================================================
    // Node identity
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            node_valid_flag_q     <= 1'b0;
            root_q                <= 1'b0;
            cable_power_ok_flag_q <= 1'b0;
            bus_id_field_q        <= `LNPC_BUS_RST;
            phys_node_field_q     <= 6'h00;
        end else begin
            cable_power_ok_flag_q <= phy_cable_power;
            // A new number wins over a reset seen in the same cycle
            if (phy_node_strobe) begin
                node_valid_flag_q <= 1'b1;
                phys_node_field_q <= phy_node_number;
            end else if (phy_bus_reset) begin
                node_valid_flag_q <= 1'b0;
            end
            if (phy_bus_reset | phy_node_strobe) begin
                root_q <= phy_is_root;
            end
            if (wr_node) begin
                bus_id_field_q <= pwdata[`LNPC_BUS_HI:`LNPC_BUS_LO];
            end
        end
    end

    // ====================================================
    // PHY mailbox registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_read_complete_q <= 1'b0;
            phy_rx_reg_addr_q   <= 4'h0;
            phy_rx_reg_value_q  <= 8'h00;
            phy_target_addr_q   <= 4'h0;
            phy_write_value_q   <= 8'h00;
        end else begin
            // Reply arriving with a new request still sets the flag
            if (phy_reg_strobe) begin
                phy_read_complete_q <= 1'b1;
                phy_rx_reg_addr_q   <= phy_reg_addr;
                phy_rx_reg_value_q  <= phy_reg_data;
            end else if (sw_rd_set | sw_wr_set) begin
                phy_read_complete_q <= 1'b0;
            end
            if (wr_phy) begin
                phy_target_addr_q <= pwdata[`LNPC_TA_HI:`LNPC_TA_LO];
                phy_write_value_q <= pwdata[`LNPC_WV_HI:0];
            end
        end
    end

    // ====================================================
    // Request serializer: start bit, type, address, data (writes only), stop bit.
    // A request bit stays set until its last bit has left.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q             <= ST_IDLE;
            shift_q             <= 17'h00000;
            left_q              <= 5'h00;
            lreq_q              <= 1'b0;
            phy_read_request_q  <= 1'b0;
            phy_write_request_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    lreq_q <= 1'b0;
                    if (sw_rd_set) begin
                        phy_read_request_q <= 1'b1;
                    end
                    if (sw_wr_set) begin
                        phy_write_request_q <= 1'b1;
                    end
                    // Read has priority should both ever be set
                    if (phy_read_request_q) begin
                        shift_q <= {1'b1, `LNPC_REQ_RD, phy_target_addr_q,
                                    1'b0, 8'h00};
                        left_q  <= `LNPC_LEN_RD;
                        state_q <= ST_SHIFT;
                    end else if (phy_write_request_q) begin
                        shift_q <= {1'b1, `LNPC_REQ_WR, phy_target_addr_q,
                                    phy_write_value_q, 1'b0};
                        left_q  <= `LNPC_LEN_WR;
                        state_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    lreq_q  <= shift_q[16];
                    shift_q <= {shift_q[15:0], 1'b0};
                    left_q  <= left_q - 5'h01;
                    if (left_q == 5'h01) begin
                        state_q <= ST_IDLE;
                        if (phy_read_request_q) begin
                            phy_read_request_q <= 1'b0;
                        end else begin
                            phy_write_request_q <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign phy_link_request = lreq_q;

    // ====================================================
    // External tick pin: three flops, level accepted when 2 and 3 agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1_q  <= 1'b0;
            ext_s2_q  <= 1'b0;
            ext_s3_q  <= 1'b0;
            ext_lvl_q <= 1'b0;
        end else begin
            ext_s1_q <= external_tick_input;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            if (ext_s2_q == ext_s3_q) begin
                ext_lvl_q <= ext_s3_q;
            end
        end
    end

    assign ext_rise = (ext_s2_q == ext_s3_q) & ext_s3_q & ~ext_lvl_q;

    // ====================================================
    // Cycle timer next value
    assign count_tick = offset_tick & time_count_enable_q;
    assign ofs_last   = (subcycle_tick_field_q == `LNPC_OFS_LAST);
    assign roll = external_rollover_select_q ? ext_rise
                                             : (count_tick & ofs_last);

    always @* begin
        sec_d = timer_seconds_field_q;
        cyc_d = cycle_number_field_q;
        ofs_d = subcycle_tick_field_q;
        if (external_rollover_select_q & ext_rise) begin
            ofs_d = 12'h000;
        end else if (count_tick) begin
            // Wrap kept even on external source in case a tick is late
            ofs_d = ofs_last ? 12'h000
                             : subcycle_tick_field_q + 12'h001;
        end
        if (roll) begin
            if (cycle_number_field_q == `LNPC_CYC_LAST) begin
                cyc_d = 13'h0000;
                sec_d = timer_seconds_field_q + 7'h01;
            end else begin
                cyc_d = cycle_number_field_q + 13'h0001;
            end
        end
    end

    // Timer registers: software write, then received start, then count
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_seconds_field_q      <= 7'h00;
            cycle_number_field_q       <= 13'h0000;
            subcycle_tick_field_q      <= 12'h000;
            time_count_enable_q        <= 1'b0;
            timing_master_enable_q     <= 1'b0;
            external_rollover_select_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                time_count_enable_q        <= pwdata[`LNPC_EN_BIT];
                timing_master_enable_q     <= pwdata[`LNPC_MASTER_BIT];
                external_rollover_select_q <= pwdata[`LNPC_SRC_BIT];
            end
            if (wr_time) begin
                timer_seconds_field_q <= pwdata[`LNPC_SEC_HI:`LNPC_SEC_LO];
                cycle_number_field_q  <= pwdata[`LNPC_CYC_HI:`LNPC_CYC_LO];
                subcycle_tick_field_q <= pwdata[`LNPC_OFS_HI:0];
            end else if (rx_cycle_start & ~timing_master_enable_q) begin
                timer_seconds_field_q <= rx_cycle_time[`LNPC_SEC_HI:`LNPC_SEC_LO];
                cycle_number_field_q  <= rx_cycle_time[`LNPC_CYC_HI:`LNPC_CYC_LO];
                subcycle_tick_field_q <= rx_cycle_time[`LNPC_OFS_HI:0];
            end else begin
                timer_seconds_field_q <= sec_d;
                cycle_number_field_q  <= cyc_d;
                subcycle_tick_field_q <= ofs_d;
            end
        end
    end

    // ====================================================
    // Cycle start as master: only when the PHY says we are root
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_pulse_q <= 1'b0;
            cs_time_q  <= 32'h00000000;
        end else begin
            cs_pulse_q <= roll & timing_master_enable_q & root_q & ~wr_time;
            if (roll & timing_master_enable_q & root_q & ~wr_time) begin
                cs_time_q <= {sec_d, cyc_d, ofs_d};
            end
        end
    end

    assign tx_cycle_start = cs_pulse_q;
    assign tx_cycle_time  = cs_time_q;

endmodule // lnpc_regs

// ### lnpc_defs.vh
// Holds the constants of the link node register block.
// Assumes inclusion by bare name from the block's design file.
`ifndef LNPC_DEFS_VH
`define LNPC_DEFS_VH
// ====================================================
// Register byte addresses
`define LNPC_ADDR_NODE   8'he8
`define LNPC_ADDR_PHY    8'hec
`define LNPC_ADDR_TIME   8'hf0
`define LNPC_ADDR_CTRL   8'hf4
// ====================================================
// Node identity fields
`define LNPC_NV_BIT      31
`define LNPC_ROOT_BIT    30
`define LNPC_CPS_BIT     27
`define LNPC_BUS_HI      15
`define LNPC_BUS_LO      6
`define LNPC_NODE_HI     5
`define LNPC_BUS_RST     10'h3ff
// ====================================================
// PHY access fields
`define LNPC_DONE_BIT    31
`define LNPC_RXA_HI      27
`define LNPC_RXA_LO      24
`define LNPC_RXV_HI      23
`define LNPC_RXV_LO      16
`define LNPC_RD_BIT      15
`define LNPC_WR_BIT      14
`define LNPC_TA_HI       11
`define LNPC_TA_LO       8
`define LNPC_WV_HI       7
// ====================================================
// Time fields and wrap points
`define LNPC_SEC_HI      31
`define LNPC_SEC_LO      25
`define LNPC_CYC_HI      24
`define LNPC_CYC_LO      12
`define LNPC_OFS_HI      11
`define LNPC_OFS_LAST    12'hbff
`define LNPC_CYC_LAST    13'h1f3f
// ====================================================
// Timer control bits
`define LNPC_EN_BIT      0
`define LNPC_MASTER_BIT  1
`define LNPC_SRC_BIT     2
// ====================================================
// Link request frame
`define LNPC_REQ_RD      3'h4
`define LNPC_REQ_WR      3'h5
`define LNPC_LEN_RD      5'h09
`define LNPC_LEN_WR      5'h11
`endif

// ### lnpc_assertions.sv
// Port-level checks for lnpc_regs, bound to every instance.
// Assumes one pclk domain with presetn as its async reset.
`timescale 1ns/1ps
module lnpc_assertions #(
    parameter ADDR_W = 8
) (
    input wire              pclk,
    input wire              presetn,
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0]       pwdata,
    input wire              pready,
    input wire              pslverr,
    input wire [31:0]       prdata,
    input wire              phy_bus_reset,
    input wire              phy_node_strobe,
    input wire [5:0]        phy_node_number,
    input wire              phy_is_root,
    input wire              phy_cable_power,
    input wire              phy_reg_strobe,
    input wire [3:0]        phy_reg_addr,
    input wire [7:0]        phy_reg_data,
    input wire              phy_link_request,
    input wire [15:0]       node_id,
    input wire              offset_tick,
    input wire              external_tick_input,
    input wire              rx_cycle_start,
    input wire [31:0]       rx_cycle_time,
    input wire              tx_cycle_start,
    input wire [31:0]       tx_cycle_time
);
    // ====
    // Decoded APB phases; read data is captured in the setup cycle
    wire rdn = psel & ~penable & ~pwrite & (paddr == 8'he8);
    wire rdp = psel & ~penable & ~pwrite & (paddr == 8'hec);
    wire wrn = psel & penable & pwrite & pready & (paddr == 8'he8);
    wire wrp = psel & penable & pwrite & pready & (paddr == 8'hec);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ====
    // Identity view, reserved bits, request framing and cycle start time
    a_node_view: assert property (rdn |=> prdata[15:0] == $past(node_id))
        else $error("node id and register view differ");
    a_node_rsvd: assert property (rdn |=> prdata[29:28] == 0 && prdata[26:16] == 0)
        else $error("node identity reserved bits not zero");
    a_bus_write: assert property (wrn |=> node_id[15:6] == $past(pwdata[15:6]))
        else $error("bus id not written");
    a_node_load: assert property (
        phy_node_strobe |=> node_id[5:0] == $past(phy_node_number))
        else $error("node number not loaded");
    a_phy_rsvd: assert property (rdp |=> prdata[30:28] == 0 && prdata[13:12] == 0)
        else $error("phy access reserved bits not zero");
    a_rd_frame: assert property (
        wrp && pwdata[15] |->
        ##[2:3] phy_link_request [*2] ##1 !phy_link_request [*2])
        else $error("read request frame wrong");
    a_wr_frame: assert property (
        wrp && pwdata[14] && !pwdata[15] |->
        ##[2:3] phy_link_request [*2] ##1 !phy_link_request ##1 phy_link_request)
        else $error("write request frame wrong");
    a_tx_time: assert property (tx_cycle_start |-> tx_cycle_time[11:0] == 12'h000)
        else $error("cycle start sent off a rollover");
endmodule // lnpc_assertions

bind lnpc_regs lnpc_assertions #(.ADDR_W(ADDR_W)) u_chk (.*);

// ### lnpc_phy_model.sv
// PHY stand-in: decodes serial register requests and answers reads.
// Assumes requests come MSB first, one bit per pclk, line idle low.
`timescale 1ns/1ps
module lnpc_phy_model (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       phy_link_request,
    input  wire       slow,
    output reg        phy_reg_strobe,
    output reg  [3:0] phy_reg_addr,
    output reg  [7:0] phy_reg_data
);
    reg [7:0] regs_q [0:15];
    reg [7:0] ty, ad, dt, sb;
    integer   i;

    // Shift n bits in, the first one ends most significant
    task automatic grab(input integer n, output reg [7:0] x);
        x = 8'h00;
        repeat (n) begin
            @(posedge pclk);
            x = {x[6:0], phy_link_request};
        end
    endtask

    // ====
    // Decode and reply; idle reply lines show the inverse of the last value
    initial begin
        for (i = 0; i < 16; i++)
            regs_q[i] = 8'h5a ^ i[7:0];
        phy_reg_strobe = 0;
        phy_reg_addr = 4'h0;
        phy_reg_data = 8'h00;
        forever begin
            @(posedge pclk);
            if (presetn === 1'b1 && phy_link_request === 1'b1) begin
                grab(3, ty);
                grab(4, ad);
                if (ty[2:0] == 3'b101) begin
                    grab(8, dt);
                    regs_q[ad[3:0]] = dt;
                end
                grab(1, sb);
                if (ty[2:0] == 3'b100) begin
                    repeat (slow ? 20 : 2) @(posedge pclk);
                    phy_reg_strobe <= 1;
                    phy_reg_addr <= ad[3:0];
                    phy_reg_data <= regs_q[ad[3:0]];
                    @(posedge pclk);
                    phy_reg_strobe <= 0;
                    phy_reg_addr <= ~ad[3:0];
                    phy_reg_data <= ~regs_q[ad[3:0]];
                end
            end
        end
    end
endmodule // lnpc_phy_model

// ### test_lnpc_regs.sv
// Self-checking bench for lnpc_regs with a PHY stand-in on the link side.
// Assumes read data is valid in the access cycle of an APB read.
`timescale 1ns/1ps
module test_lnpc_regs;
    typedef struct { logic err; logic [31:0] d, m; } lnpc_exp_t;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, rx_cycle_time = 0, rnd = 32'h0cf3f6e5, t, tx_t = 0;
    logic        phy_bus_reset = 0, phy_node_strobe = 0, phy_is_root = 0, slow = 0;
    logic        phy_cable_power = 0, offset_tick = 0, external_tick_input = 0;
    logic        rx_cycle_start = 0;
    logic [5:0]  phy_node_number = 0;
    logic [9:0]  b;
    logic [3:0]  a, pa = 0;
    logic [7:0]  v, pd = 0;
    wire         pready, pslverr, phy_link_request, tx_cycle_start, phy_reg_strobe;
    wire  [31:0] prdata, tx_cycle_time;
    wire  [15:0] node_id;
    wire  [3:0]  phy_reg_addr;
    wire  [7:0]  phy_reg_data;
    integer      fails = 0, n_tests = 0, cycles = 0, tx_n = 0, i, k;
    lnpc_exp_t   q[$];
    lnpc_exp_t   e;

    always #10 pclk = ~pclk;
    lnpc_regs dut_u (.*);
    lnpc_phy_model phy_u (.*);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        n_tests++;
        if (g !== ex) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, ex, g);
        end
    endtask
    // Release the bus, then let n edges pass
    task automatic step(input int n);
        psel <= 0;
        penable <= 0;
        repeat (n) @(posedge pclk);
    endtask
    // Request held until pready is seen high; caller releases
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] ex,
                      input logic [31:0] m = 32'hffffffff, input logic er = 1'b0);
        q.push_back(lnpc_exp_t'{er, ex & m, m});
        apb(0, ad, 32'h0);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            offset_tick <= 1;
            step(1);
            offset_tick <= 0;
            step(1);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ====
    // Watcher: each read result is compared with the oldest note
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 20000) begin
            fails++;
            report_and_stop();
        end
        if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            chk("prdata", e.d, prdata & e.m);
            chk("pslverr", {31'h0, e.err}, {31'h0, pslverr});
        end
        if (tx_cycle_start === 1'b1) begin
            tx_n++;
            tx_t = tx_cycle_time;
        end
    end

    // ====
    // Main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rd(8'he8, 32'h0000ffc0);
        rd(8'hec, 32'h0);
        rd(8'hf0, 32'h0);
        rd(8'h10, 32'h0, 32'hffffffff, 1'b1);
        rnd = lfsr(rnd);
        b = rnd[15:6];
        apb(1, 8'he8, rnd);
        rd(8'he8, {16'h0, b, 6'h0});
        step(1);
        chk("node_id", {16'h0, b, 6'h0}, {16'h0, node_id});
        // Bus reset drops the valid flag until a new node number lands
        phy_is_root <= 1;
        phy_cable_power <= 1;
        phy_bus_reset <= 1;
        step(1);
        phy_bus_reset <= 0;
        step(2);
        rd(8'he8, 32'h0, 32'h80000000);
        phy_node_strobe <= 1;
        phy_node_number <= 6'h3f;
        step(1);
        phy_node_strobe <= 0;
        phy_node_number <= 6'h00;
        step(1);
        // Node 63 arrives with root and cable power still set
        rd(8'he8, {8'hc8, 8'h00, b, 6'h3f});
        step(1);
        chk("node_id", {16'h0, b, 6'h3f}, {16'h0, node_id});
        phy_cable_power <= 0;
        step(2);
        rd(8'he8, 32'h0, 32'h08000000);
        // PHY writes then reads back, prompt and slow, edge addresses
        for (i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            a = (i == 0) ? 4'h0 : (i == 3) ? 4'hf : rnd[3:0];
            v = rnd[11:4];
            slow <= i[0];
            apb(1, 8'hec, {rnd[31:16], 2'b01, rnd[13:12], a, v});
            step(24);
            rd(8'hec, {4'h0, pa, pd, 4'h0, a, v});
            rnd = lfsr(rnd);
            apb(1, 8'hec, {rnd[31:16], 2'b10, rnd[13:12], a, rnd[7:0]});
            step(1);
            for (k = 0; k < 80 && phy_reg_strobe !== 1'b1; k++)
                step(1);
            step(2);
            rd(8'hec, {4'h8, a, v, 4'h0, a, rnd[7:0]});
            pa = a;
            pd = v;
        end
        // Timer crossing every wrap point, then frozen while disabled
        apb(1, 8'hf4, 32'h1);
        apb(1, 8'hf0, {7'h7f, 13'd7999, 12'd3070});
        ticks(1);
        rd(8'hf0, {7'h7f, 13'd7999, 12'd3071});
        ticks(1);
        rd(8'hf0, 32'h0);
        apb(1, 8'hf4, 32'h0);
        apb(1, 8'hf0, 32'h00012345);
        ticks(5);
        rd(8'hf0, 32'h00012345);
        apb(1, 8'hf4, 32'h3);
        apb(1, 8'hf0, {7'h01, 13'd5, 12'd3071});
        ticks(1);
        step(2);
        chk("tx_count", 32'd1, tx_n);
        chk("tx_time", {7'h01, 13'd6, 12'h0}, tx_t);
        // A received cycle start must leave the master's own timer alone
        rx_cycle_time <= 32'h12345678;
        rx_cycle_start <= 1;
        step(1);
        rx_cycle_start <= 0;
        rd(8'hf0, {7'h01, 13'd6, 12'h0});
        apb(1, 8'hf4, 32'h1);
        step(1);
        rnd = lfsr(rnd);
        t = {rnd[31:25], 1'b0, rnd[23:12], 1'b0, rnd[10:0]};
        rx_cycle_time <= t;
        rx_cycle_start <= 1;
        step(1);
        rx_cycle_start <= 0;
        rx_cycle_time <= ~t;
        step(1);
        rd(8'hf0, t);
        apb(1, 8'hf4, 32'h5);
        apb(1, 8'hf0, {7'h0, 13'd10, 12'd100});
        step(1);
        external_tick_input <= 1;
        step(6);
        external_tick_input <= 0;
        step(2);
        rd(8'hf0, {7'h0, 13'd11, 12'd0});
        step(4);
        chk("pending", 32'd0, q.size());
        report_and_stop();
    end
endmodule // test_lnpc_regs
